// ### mrx_consts.svh
// Behaviour
// RULE1: loop_hold 0 lets the bit clock track the data; 1 holds its phase.
// RULE2: Software keeps loop_hold at 0, setting it only across short data gaps.
// RULE3: squelch_threshold code 0000 needs 62 correct samples, each step two fewer.
// RULE4: A bit period nominally holds 50 samples at 10 kHz, 63 at 8 kHz.
// RULE5: At each bit end, flag the bit approved if correct samples reach threshold.
// RULE6: Count approved bits per byte, 0 to 8, published with the byte.
// RULE7: Shift bits through 11 stages and decode Barker pattern 11100010010.
// RULE8: Word-sync interrupt fires on every Barker match regardless of reframe_enable.
// RULE9: Control channel, reframe off: no Barker reframing, busy/idle bits stripped.
// RULE10: Control channel, reframe on: realign on Barker, busy/idle bits kept.
// RULE11: Voice channel: busy/idle/SAT interrupt marks SAT; reframing follows reframe_enable.
// RULE12: channel_type is bit 0 of the sync-mode port: 0 control, 1 voice.
// RULE13: First received bit of a byte lands in the byte's most significant bit.
// RULE14: All bits except stripped busy/idle bits reach the received byte.
// RULE15: Receive-byte interrupt fires whenever byte and squelch count update together.
// RULE16: Extracted busy/idle bit reads at level/status bit 6; updates raise interrupt.
// RULE17: Software reads byte and squelch count promptly after the interrupt.
// RULE18: Byte interrupt recurs every eight kept bits, one bit longer when stripping.
// RULE19: Bit value is decided by majority of the samples taken at 504 kHz.
// RULE20: Modem soft reset clears byte, frame, Barker and tally state.
`ifndef MRX_CONSTS_SVH
`define MRX_CONSTS_SVH

// APB register byte offsets
`define MRX_OFS_SYNC_MODE 12'h000
`define MRX_OFS_LEVEL_STATUS 12'h004
`define MRX_OFS_BYTE 12'h008
`define MRX_OFS_LOOP_CTRL 12'h00C

// Field positions
`define MRX_BIT_CHAN_TYPE 0
`define MRX_BIT_REFRAME 1
`define MRX_BIT_SYNC_DET 2
`define MRX_BIT_BUSY_IDLE 6
`define MRX_BIT_SYS_8K 0
`define MRX_BIT_LOOP_HOLD 5
`define MRX_BIT_SOFT_RST 7

// Reset values
`define MRX_RST_SYNC_MODE 8'h02
`define MRX_RST_THRESHOLD 4'h0
`define MRX_RST_LOOP_CTRL 8'h00

// Bit timing in 504 kHz samples, and the Barker pattern
`define MRX_NOM_10K 7'h32
`define MRX_NOM_8K 7'h3F
`define MRX_THR_BASE 7'h3E
`define MRX_BARKER 11'h712

// Frame structure
`define MRX_FRAME_BITS 9'h1CF
`define MRX_BI_SPACING 4'hA
`define MRX_BYTE_LAST 3'h7

`endif

// ### mrx_pkg.sv
`default_nettype none
package mrx_pkg;
  // One 504 kHz sample from the decoder with the loop's phase verdicts
  typedef struct packed {
    logic tick;
    logic sample;
    logic early;
    logic late;
  } mrx_dec_type;

  typedef struct packed {
    logic word_sync;
    logic rx_byte;
    logic busy_idle_sat;
  } mrx_irq_type;

  typedef enum logic [1:0] {
    MRX_BUS_IDLE = 2'b01,
    MRX_BUS_RESP = 2'b10
  } mrx_bus_type;
endpackage
`default_nettype wire

// ### mrx_word_sync.sv
`include "mrx_consts.svh"
`default_nettype none
module mrx_word_sync
  import mrx_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Data decoder
  input wire mrx_dec_type dec_in,
  input wire logic sat_update_in,
  // Events
  output mrx_irq_type irq_out,
  output logic bit_clk_out
);

  // ********************************************
  // Register file over APB
  // ********************************************
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  mrx_bus_type bus_ff, nxt_bus;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [7:0] mode_ff, nxt_mode;
  logic [3:0] thr_ff, nxt_thr;
  logic [1:0] lvl_misc_ff, nxt_lvl_misc;
  logic [7:0] loop_ff, nxt_loop;
  logic soft_rst_ff, nxt_soft_rst;
  logic [7:0] byte_ff;
  logic [3:0] sqcnt_ff;
  logic busy_idle_ff;
  logic mapped;
  logic wr_done;

  always_comb begin
    mapped = hit(paddr_in, `MRX_OFS_SYNC_MODE) |
             hit(paddr_in, `MRX_OFS_LEVEL_STATUS) |
             hit(paddr_in, `MRX_OFS_BYTE) |
             hit(paddr_in, `MRX_OFS_LOOP_CTRL);
    wr_done = psel_in & penable_in & pready_ff & pwrite_in & mapped;
    nxt_bus = bus_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_mode = mode_ff;
    nxt_thr = thr_ff;
    nxt_lvl_misc = lvl_misc_ff;
    nxt_loop = loop_ff;
    nxt_soft_rst = 1'b0;
    case (bus_ff)
      MRX_BUS_IDLE: begin
        // One wait state lets read data come straight from a flop
        if (psel_in & penable_in) begin
          nxt_bus = MRX_BUS_RESP;
          nxt_pready = 1'b1;
          nxt_pslverr = ~mapped;
          nxt_prdata = 32'h0000_0000;
          if (hit(paddr_in, `MRX_OFS_SYNC_MODE))
            nxt_prdata[7:0] = mode_ff;
          if (hit(paddr_in, `MRX_OFS_LEVEL_STATUS))
            nxt_prdata[7:0] = {1'b0, busy_idle_ff, lvl_misc_ff,
                               sqcnt_ff}; // [RULE16]
          if (hit(paddr_in, `MRX_OFS_BYTE))
            nxt_prdata[7:0] = byte_ff;
          if (hit(paddr_in, `MRX_OFS_LOOP_CTRL))
            nxt_prdata[7:0] = {1'b0, loop_ff[6:0]};
        end
      end
      MRX_BUS_RESP: begin
        nxt_bus = MRX_BUS_IDLE;
        if (wr_done & hit(paddr_in, `MRX_OFS_SYNC_MODE))
          nxt_mode = pwdata_in[7:0]; // [RULE12]
        if (wr_done & hit(paddr_in, `MRX_OFS_LEVEL_STATUS)) begin
          nxt_thr = pwdata_in[3:0];
          nxt_lvl_misc = pwdata_in[5:4];
        end
        if (wr_done & hit(paddr_in, `MRX_OFS_LOOP_CTRL)) begin
          nxt_loop = {1'b0, pwdata_in[6:0]};
          nxt_soft_rst = pwdata_in[`MRX_BIT_SOFT_RST];
        end
      end
      default: nxt_bus = MRX_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus_ff <= MRX_BUS_IDLE;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      mode_ff <= `MRX_RST_SYNC_MODE;
      thr_ff <= `MRX_RST_THRESHOLD;
      lvl_misc_ff <= 2'h0;
      loop_ff <= `MRX_RST_LOOP_CTRL;
      soft_rst_ff <= 1'b0;
    end else begin
      bus_ff <= nxt_bus;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      mode_ff <= nxt_mode;
      thr_ff <= nxt_thr;
      lvl_misc_ff <= nxt_lvl_misc;
      loop_ff <= nxt_loop;
      soft_rst_ff <= nxt_soft_rst;
    end
  end

  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;

  // ********************************************
  // Bit decision and word sync
  // ********************************************
  logic chan_voice;
  logic reframe_en;
  logic loop_hold;
  logic [6:0] nominal;
  logic [6:0] threshold;
  assign chan_voice = mode_ff[`MRX_BIT_CHAN_TYPE];
  assign reframe_en = mode_ff[`MRX_BIT_REFRAME];
  assign loop_hold = loop_ff[`MRX_BIT_LOOP_HOLD];
  // [RULE4]
  assign nominal = loop_ff[`MRX_BIT_SYS_8K] ? `MRX_NOM_8K : `MRX_NOM_10K;
  assign threshold = `MRX_THR_BASE - {2'b00, thr_ff, 1'b0}; // [RULE3]

  logic [6:0] samp_ff, nxt_samp;
  logic [6:0] ones_ff, nxt_ones;
  logic [6:0] len_ff, nxt_len;
  logic [10:0] bsh_ff, nxt_bsh;
  logic [7:0] acc_ff, nxt_acc;
  logic [2:0] bpos_ff, nxt_bpos;
  logic [3:0] tally_ff, nxt_tally;
  logic [3:0] bi_ff, nxt_bi;
  logic [8:0] frm_ff, nxt_frm;
  logic [7:0] nxt_byte;
  logic [3:0] nxt_sqcnt;
  logic nxt_busy_idle;
  mrx_irq_type irq_ff, nxt_irq;
  logic bclk_ff, nxt_bclk;
  logic bit_end, bit_val, approved, barker, strip, realign;
  logic [6:0] ones_all, zeros_all, correct;

  always_comb begin
    nxt_samp = samp_ff;
    nxt_ones = ones_ff;
    nxt_len = len_ff;
    nxt_bsh = bsh_ff;
    nxt_acc = acc_ff;
    nxt_bpos = bpos_ff;
    nxt_tally = tally_ff;
    nxt_bi = bi_ff;
    nxt_frm = frm_ff;
    nxt_byte = byte_ff;
    nxt_sqcnt = sqcnt_ff;
    nxt_busy_idle = busy_idle_ff;
    nxt_irq = '0;
    bit_end = dec_in.tick & (samp_ff + 7'h01 >= len_ff);
    ones_all = ones_ff + {6'h00, dec_in.sample};
    zeros_all = len_ff - ones_all;
    bit_val = ones_all > zeros_all; // [RULE19]
    correct = bit_val ? ones_all : zeros_all;
    approved = correct >= threshold; // [RULE5]
    barker = bit_end & ({bsh_ff[9:0], bit_val} == `MRX_BARKER); // [RULE7]
    strip = ~chan_voice & ~reframe_en & (bi_ff == `MRX_BI_SPACING); // [RULE9]
    realign = (barker & reframe_en) | // [RULE10] [RULE11]
              (bit_end & ~reframe_en & ~chan_voice &
               (frm_ff == `MRX_FRAME_BITS - 9'h001));
    nxt_bclk = (samp_ff < {1'b0, len_ff[6:1]});
    if (dec_in.tick) begin
      nxt_samp = samp_ff + 7'h01;
      nxt_ones = ones_all;
    end
    if (bit_end) begin
      nxt_samp = 7'h00;
      nxt_ones = 7'h00;
      // Hold keeps the nominal period so the phase stays where it is
      nxt_len = nominal; // [RULE1]
      if (!loop_hold & dec_in.early)
        nxt_len = nominal - 7'h01; // [RULE1]
      else if (!loop_hold & dec_in.late)
        nxt_len = nominal + 7'h01; // [RULE1]
      nxt_bsh = {bsh_ff[9:0], bit_val};
      nxt_irq.word_sync = barker; // [RULE8]
      nxt_frm = frm_ff + 9'h001;
      nxt_bi = (bi_ff == `MRX_BI_SPACING) ? 4'h0 : bi_ff + 4'h1;
      if (strip) begin
        nxt_busy_idle = bit_val; // [RULE16]
        nxt_irq.busy_idle_sat = 1'b1; // [RULE16]
      end else begin
        nxt_acc = {acc_ff[6:0], bit_val}; // [RULE13] [RULE14]
        nxt_tally = tally_ff + {3'h0, approved}; // [RULE6]
        nxt_bpos = bpos_ff + 3'h1;
        if (bpos_ff == `MRX_BYTE_LAST) begin
          nxt_byte = {acc_ff[6:0], bit_val}; // [RULE15]
          nxt_sqcnt = tally_ff + {3'h0, approved}; // [RULE6]
          nxt_irq.rx_byte = 1'b1; // [RULE15] [RULE18]
          nxt_tally = 4'h0;
        end
      end
      // A realigned stream starts a fresh byte on the next bit
      if (realign) begin
        nxt_bpos = 3'h0;
        nxt_tally = 4'h0;
        nxt_bi = 4'h0;
        nxt_frm = 9'h000;
      end
    end
    if (chan_voice & sat_update_in)
      nxt_irq.busy_idle_sat = 1'b1; // [RULE11]
    if (soft_rst_ff) begin
      nxt_samp = 7'h00;
      nxt_ones = 7'h00;
      nxt_bsh = 11'h000; // [RULE20]
      nxt_bpos = 3'h0; // [RULE20]
      nxt_tally = 4'h0; // [RULE20]
      nxt_bi = 4'h0;
      nxt_frm = 9'h000; // [RULE20]
      nxt_irq = '0;
      // Reload the period so a new system rate holds from the first bit
      nxt_len = nominal; // [RULE4]
      // Hold byte and flags so no update goes by without its interrupt
      nxt_byte = byte_ff; // [RULE15]
      nxt_sqcnt = sqcnt_ff; // [RULE15]
      nxt_busy_idle = busy_idle_ff; // [RULE16]
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      samp_ff <= 7'h00;
      ones_ff <= 7'h00;
      len_ff <= `MRX_NOM_10K;
      bsh_ff <= 11'h000;
      acc_ff <= 8'h00;
      bpos_ff <= 3'h0;
      tally_ff <= 4'h0;
      bi_ff <= 4'h0;
      frm_ff <= 9'h000;
      byte_ff <= 8'h00;
      sqcnt_ff <= 4'h0;
      busy_idle_ff <= 1'b0;
      irq_ff <= '0;
      bclk_ff <= 1'b0;
    end else begin
      samp_ff <= nxt_samp;
      ones_ff <= nxt_ones;
      len_ff <= nxt_len;
      bsh_ff <= nxt_bsh;
      acc_ff <= nxt_acc;
      bpos_ff <= nxt_bpos;
      tally_ff <= nxt_tally;
      bi_ff <= nxt_bi;
      frm_ff <= nxt_frm;
      byte_ff <= nxt_byte;
      sqcnt_ff <= nxt_sqcnt;
      busy_idle_ff <= nxt_busy_idle;
      irq_ff <= nxt_irq;
      bclk_ff <= nxt_bclk;
    end
  end

  assign irq_out = irq_ff;
  assign bit_clk_out = bclk_ff;

  // ********************************************
  // Checks
  // ********************************************
  hold_period_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    bit_end & loop_hold & !soft_rst_ff |=> len_ff == nominal) // [RULE1]
    else $error("held loop changed the bit period");

  thr_map_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (thr_ff == 4'hF) |-> threshold == 7'd32) // [RULE3]
    else $error("squelch code 1111 does not need 32 samples");

  nom_len_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    loop_ff[`MRX_BIT_SYS_8K] |-> nominal == 7'd63) // [RULE4]
    else $error("8 kHz nominal sample count wrong");

  sq_range_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    irq_ff.rx_byte |-> sqcnt_ff <= 4'h8) // [RULE6]
    else $error("squelch count above eight");

  ws_irq_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    barker & !soft_rst_ff |=> irq_ff.word_sync) // [RULE8]
    else $error("Barker match without word-sync pulse");

  strip_keep_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    bit_end & strip & !soft_rst_ff |=> $stable(acc_ff)) // [RULE9]
    else $error("busy/idle bit entered the byte");

  reframe_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    barker & reframe_en |=> bpos_ff == 3'h0) // [RULE10]
    else $error("Barker did not realign the byte");

  byte_msb_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    irq_ff.rx_byte |-> byte_ff[0] == $past(bit_val)) // [RULE13]
    else $error("last received bit not in byte LSB");

  bi_voice_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    chan_voice & sat_update_in & !soft_rst_ff |=> irq_ff.busy_idle_sat)
    // [RULE11]
    else $error("SAT update did not raise interrupt");

  bi_read_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    irq_ff.busy_idle_sat & !chan_voice |-> busy_idle_ff == $past(bit_val))
    // [RULE16]
    else $error("busy/idle flag not the stripped bit");

  byte_upd_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    !irq_ff.rx_byte |-> $stable(byte_ff) && $stable(sqcnt_ff)) // [RULE15]
    else $error("byte or squelch count changed without interrupt");

  soft_clr_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    soft_rst_ff |=> bsh_ff == 11'h000 && bpos_ff == 3'h0 &&
    tally_ff == 4'h0 && frm_ff == 9'h000) // [RULE20]
    else $error("soft reset left alignment state behind");

  bi_irq_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    bit_end & strip & !soft_rst_ff |=> irq_ff.busy_idle_sat) // [RULE16]
    else $error("stripped bit raised no busy/idle interrupt");

  keep_bit_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    bit_end & !strip & !soft_rst_ff |=>
    acc_ff[0] == $past(bit_val)) // [RULE14]
    else $error("kept bit did not enter the byte");

  sq_sum_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    irq_ff.rx_byte |->
    sqcnt_ff == $past(tally_ff) + {3'h0, $past(approved)}) // [RULE6]
    else $error("squelch count is not the approved tally");

endmodule
`default_nettype wire

// ### mrx_dec_model.sv
`default_nettype none
module mrx_dec_model
  import mrx_pkg::*;
(
  // Clock
  input wire logic clk_sys_in,
  // Decoder stream
  output mrx_dec_type dec_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Sample stream
  // ****************
  int len = 50;
  logic early = 1'h0;
  initial dec_out = '0;
  // The last bad samples of a bit are inverted; sample toggles between ticks
  task automatic send_bit(input logic b, input int bad);
    for (int i = 0; i < len; i++) begin
      @(posedge clk_sys_in);
      dec_out <= '{1'h1, (i < len - bad) ? b : ~b, early, 1'h0};
      @(posedge clk_sys_in);
      dec_out <= '{1'h0, ~dec_out.sample, 1'h0, 1'h0};
    end
  endtask
  // First bit sent is the most significant of the n given
  task automatic send_bits(input logic [15:0] v, input int n, input int bad);
    for (int i = n - 1; i >= 0; i--) begin
      send_bit(v[i], bad);
    end
  endtask
endmodule
`default_nettype wire

// ### tb.sv
`include "mrx_consts.svh"
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("BAD %s exp %0h got %0h", nm, e, g); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mrx_pkg::*;
  // ****************
  // Hookup
  // ****************
  logic clk_sys_in, nrst_in, psel_in, penable_in, pwrite_in, sat_update_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rdat;
  logic pready_out, pslverr_out, bit_clk_out, rerr, bc_q;
  mrx_dec_type dec_in;
  mrx_irq_type irq_out;
  int fail_count = 0, compares = 0, n_ws = 0, n_rx = 0, n_bi = 0, k0, k1;
  int n_bc = 0, k2;
  mrx_word_sync DUT (.clk_sys_in, .nrst_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .dec_in, .sat_update_in, .irq_out, .bit_clk_out);
  mrx_dec_model dec (.clk_sys_in, .dec_out(dec_in));
  initial begin
    clk_sys_in = 1'h0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    n_ws += (irq_out.word_sync === 1'h1);
    n_rx += (irq_out.rx_byte === 1'h1);
    n_bi += (irq_out.busy_idle_sat === 1'h1);
    n_bc += (bit_clk_out === 1'h1 && bc_q === 1'h0);
    bc_q = bit_clk_out;
  end
  // ****************
  // Tasks
  // ****************
  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    psel_in <= 1'h1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h0, d};
    @(posedge clk_sys_in);
    penable_in <= 1'h1;
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (pready_out !== 1'h1 && k < 20);
    if (pready_out !== 1'h1) begin
      fail_count++;
      summarize();
    end
    rdat = prdata_out;
    rerr = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
    @(posedge clk_sys_in);
  endtask
  // Upper half sent with b0 bad samples a bit, lower half with b1
  task automatic xbyte(input logic [7:0] v, input int b0, input int b1);
    dec.send_bits({12'h0, v[7:4]}, 4, b0);
    dec.send_bits({12'h0, v[3:0]}, 4, b1);
    repeat (3) @(posedge clk_sys_in);
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    fail_count++;
    summarize();
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    {nrst_in, psel_in, penable_in, pwrite_in, sat_update_in} = 5'h0;
    paddr_in = 12'h0;
    pwdata_in = 32'h0;
    repeat (20) @(posedge clk_sys_in);
    nrst_in <= 1'h1;
    @(posedge clk_sys_in);
    apb(1'h0, `MRX_OFS_SYNC_MODE, 8'h00);
    `CHK("sync_mode", 32'h02, rdat);
    apb(1'h0, 12'h010, 8'h00);
    `CHK("unmapped_err", 1'h1, rerr);
    `CHK("unmapped_data", 32'h0, rdat);
    dec.send_bits(16'h0712, 11, 0);
    repeat (3) @(posedge clk_sys_in);
    `CHK("ws_count", 1, n_ws);
    // Codes 6 to 15 are each hit exactly at their sample count, then one short; code 5 is out of reach
    for (int c = 5; c < 16; c++) begin
      apb(1'h1, `MRX_OFS_LEVEL_STATUS, 8'(c));
      k0 = n_rx;
      xbyte(8'h5A ^ 8'(c), (c == 5) ? 0 : 2 * c - 12, 2 * c - 11);
      apb(1'h0, `MRX_OFS_BYTE, 8'h00);
      `CHK("byte", 8'h5A ^ 8'(c), rdat[7:0]);
      apb(1'h0, `MRX_OFS_LEVEL_STATUS, 8'h00);
      `CHK("sq_count", (c == 5) ? 4'h0 : 4'h4, rdat[3:0]);
      `CHK("rx_irq", k0 + 1, n_rx);
    end
    // Misaligned by three bits, then soft reset with the loop held
    dec.send_bits(16'h0005, 3, 0);
    apb(1'h1, `MRX_OFS_LOOP_CTRL, 8'hA0);
    dec.early = 1'h1;
    xbyte(8'h96, 0, 0);
    dec.early = 1'h0;
    apb(1'h0, `MRX_OFS_BYTE, 8'h00);
    `CHK("byte_after_rst", 8'h96, rdat[7:0]);
    apb(1'h0, `MRX_OFS_LOOP_CTRL, 8'h00);
    `CHK("loop_ctrl", 32'h20, rdat);
    // Soft reset again so the busy/idle position restarts at zero
    apb(1'h1, `MRX_OFS_LOOP_CTRL, 8'h80);
    apb(1'h1, `MRX_OFS_SYNC_MODE, 8'h00);
    k0 = n_ws;
    k1 = n_bi;
    k2 = n_rx;
    // The 11th and 22nd bits are stripped: a 0, then a 1
    dec.send_bits(16'h0712, 11, 0);
    dec.send_bits(16'h0001, 11, 0);
    repeat (3) @(posedge clk_sys_in);
    `CHK("ws_no_reframe", k0 + 1, n_ws);
    `CHK("bi_irq", k1 + 2, n_bi);
    `CHK("rx_kept", k2 + 2, n_rx);
    apb(1'h0, `MRX_OFS_LEVEL_STATUS, 8'h00);
    `CHK("bi_bit", 1'h1, rdat[6]);
    // A reframe on the Barker would have given 00 here
    apb(1'h0, `MRX_OFS_BYTE, 8'h00);
    `CHK("byte_no_reframe", 8'h40, rdat[7:0]);
    apb(1'h1, `MRX_OFS_SYNC_MODE, 8'h01);
    k1 = n_bi;
    sat_update_in <= 1'h1;
    @(posedge clk_sys_in);
    sat_update_in <= 1'h0;
    repeat (3) @(posedge clk_sys_in);
    `CHK("sat_irq", k1 + 1, n_bi);
    // 8 kHz system from a fresh start, strictest squelch code
    apb(1'h1, `MRX_OFS_LOOP_CTRL, 8'h81);
    apb(1'h1, `MRX_OFS_LEVEL_STATUS, 8'h00);
    dec.len = 63;
    k0 = n_rx;
    k1 = n_bc;
    xbyte(8'hC3, 1, 2);
    apb(1'h0, `MRX_OFS_BYTE, 8'h00);
    `CHK("byte_8k", 8'hC3, rdat[7:0]);
    apb(1'h0, `MRX_OFS_LEVEL_STATUS, 8'h00);
    `CHK("sq_8k", 4'h4, rdat[3:0]);
    `CHK("rx_irq_8k", k0 + 1, n_rx);
    `CHK("bit_clk_8k", k1 + 8, n_bc);
    summarize();
  end
endmodule
`default_nettype wire
